// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench
  import tple_pkg::*;
;
  logic clk, resetn, wr, rd, tick, wvalid, wready, clear;
  logic la, lb, mp, mn, sb, sv;
  logic fmark = 1'b0;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, same_v, mon_bad, nb, sub_ones, sub_steps;
  logic [15:0] marks, viols;
  tple_word_type word;
  int n_errors = 0;
  int check_count = 0;
  int bitno = 0;
  logic [15:0] mode [7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
                            16'h0004, 16'h1004, 16'h1001};
  logic [15:0] expm [7] = '{16'h0000, 16'h1008, 16'h0400, 16'h0C00,
                            16'h0200, 16'h0000, 16'h1008};
  logic [7:0] exps [7] = '{8'h00, 8'h00, 8'h04, 8'h0C, 8'h02, 8'h00, 8'h00};
  logic [8:0] regs [6] = '{ADDR_CFG_ZERO, ADDR_CFG_ONE, ADDR_PAT_CFG,
                           ADDR_LOOP_CFG, ADDR_LOOP_PAT, ADDR_CHAN_BASE};

  tple_encoder u_tple_encoder (.i_mclk(clk), .i_resetn(resetn),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_line_tick(tick), .i_word(word), .i_word_valid(wvalid),
    .o_word_ready(wready), .o_sub_bit(sb), .o_sub_valid(sv),
    .o_line_out_a(la), .o_line_out_b(lb),
    .o_monitor_positive_rail(mp), .o_monitor_negative_rail(mn));
  tple_line_partner u_tple_line_partner (.i_mclk(clk), .i_resetn(resetn),
    .i_tick(tick), .i_clear(clear), .i_line_a(la), .i_line_b(lb),
    .i_mon_p(mp), .i_mon_n(mn), .o_marks(marks), .o_viols(viols),
    .o_same_v(same_v), .o_mon_bad(mon_bad));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ones and steps seen on the substituted data tap
  always @(posedge clk) begin
    if (!resetn || clear) begin
      sub_ones <= 8'h00;
      sub_steps <= 8'h00;
    end else if (sv) begin
      sub_steps <= sub_steps + 8'h01;
      sub_ones <= sub_ones + {7'h00, sb};
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register write: strobe held for one cycle
  task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // register read: data sampled once the registered answer settled
  task automatic reg_rd(input logic [8:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // push one line bit, then give it one line tick
  task automatic step(input logic d);
    int n;
    n = 0;
    while (wready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 50) begin
        n_errors++;
        conclude();
      end
    end
    word = '0;
    word.data = d;
    word.frame = fmark && (bitno % 193 == 0);
    word.ts = 5'((bitno / 8) % 24);
    word.pos = 3'(bitno % 8);
    wvalid = 1'b1;
    @(negedge clk);
    wvalid = 1'b0;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    bitno++;
  endtask

  task automatic run(input logic d, input int n);
    for (int k = 0; k < n; k++) step(d);
    // let the partner count the last step before anyone looks
    @(negedge clk);
  endtask

  task automatic clr();
    @(negedge clk);
    clear = 1'b1;
    @(negedge clk);
    clear = 1'b0;
  endtask

  initial begin
    {resetn, wr, rd, tick, wvalid, clear} = '0;
    addr = '0;
    wdata = '0;
    word = '0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    // reset values, including an unmapped place
    foreach (regs[i]) reg_rd(regs[i], RST_BYTE);
    reg_rd(ADDR_ERR_INS, RST_BYTE);
    reg_wr(9'h07F, 8'hFF);
    reg_rd(9'h07F, 8'h00);
    foreach (regs[i]) begin
      reg_wr(regs[i], 8'hA5);
      reg_rd(regs[i], 8'hA5);
      reg_wr(regs[i], 8'h00);
    end
    $display("test registers done");
    for (int c = 0; c < 32; c++) reg_wr(ADDR_CHAN_BASE + 9'(c), 8'h01);
    run(1'b1, 40);
    // long zero runs under each line code, 32-bit window counts
    for (int i = 0; i < 7; i++) begin
      reg_wr(ADDR_CFG_ZERO, mode[i][15:8]);
      reg_wr(ADDR_CFG_ONE, mode[i][7:0]);
      run(1'b0, 64);
      clr();
      run(1'b0, 32);
      chk(marks, {8'h00, expm[i][15:8]});
      chk(viols, {8'h00, expm[i][7:0]});
      chk({8'h00, sub_ones}, {8'h00, exps[i]});
      chk({8'h00, sub_steps}, 16'h0020);
    end
    chk({8'h00, same_v}, 16'h0000);
    $display("test line codes done");
    reg_wr(ADDR_CFG_ZERO, 8'h00);
    reg_wr(ADDR_CFG_ONE, 8'h00);
    run(1'b1, 40);
    clr();
    reg_wr(ADDR_ERR_INS, 8'h00);
    run(1'b1, 24);
    chk(viols, 16'h0000);
    reg_wr(ADDR_ERR_INS, 8'h01);
    run(1'b1, 40);
    reg_rd(ADDR_ERR_INS, 8'h00);
    chk(viols, 16'h0001);
    $display("test violation insert done");
    // fill the fifo without ticks, then drain it
    word = '0;
    word.data = 1'b1;
    wvalid = 1'b1;
    repeat (FIFO_DEPTH) @(negedge clk);
    wvalid = 1'b0;
    chk({15'h0000, wready}, 16'h0000);
    repeat (FIFO_DEPTH) begin
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      @(negedge clk);
    end
    chk({15'h0000, wready}, 16'h0001);
    $display("test fifo done");
    // shortest prbs: one full period holds 1024 ones
    reg_wr(ADDR_PAT_CFG, 8'h10);
    run(1'b1, 40);
    clr();
    run(1'b1, 2047);
    chk(marks, 16'd1024);
    chk(viols, 16'h0000);
    reg_wr(ADDR_ERR_INS, 8'h20);
    run(1'b1, 8);
    reg_rd(ADDR_ERR_INS, 8'h00);
    reg_wr(ADDR_PAT_CFG, 8'h00);
    run(1'b0, 40);
    clr();
    run(1'b0, 32);
    chk(marks, 16'h0000);
    chk({8'h00, mon_bad}, 16'h0000);
    $display("test prbs done");
    // zero limit only adds forced marks to a full period
    reg_wr(ADDR_PAT_CFG, 8'h14);
    run(1'b0, 40);
    clr();
    run(1'b0, 2047);
    chk({15'h0000, marks > 16'd1024}, 16'h0001);
    $display("test zero limit done");
    // framed: pattern pauses on framing bits, one frame error
    fmark = 1'b1;
    bitno = 0;
    reg_wr(ADDR_PAT_CFG, 8'h18);
    reg_wr(ADDR_ERR_INS, 8'h02);
    run(1'b0, 40);
    reg_rd(ADDR_ERR_INS, 8'h00);
    clr();
    run(1'b0, 2057);
    chk(marks, 16'd1024);
    fmark = 1'b0;
    reg_wr(ADDR_PAT_CFG, 8'h00);
    $display("test framed prbs done");
    // six-bit loop code holding a single one
    reg_wr(ADDR_LOOP_PAT, 8'h01);
    reg_wr(ADDR_LOOP_CFG, 8'h05);
    run(1'b0, 40);
    clr();
    run(1'b0, 36);
    chk(marks, 16'h0006);
    reg_wr(ADDR_LOOP_CFG, 8'h00);
    $display("test loop code done");
    // nrz monitor: line untouched, negative marks now differ
    reg_wr(ADDR_CFG_ONE, 8'h08);
    run(1'b1, 40);
    clr();
    nb = mon_bad;
    run(1'b1, 32);
    chk(marks, 16'h0020);
    chk({8'h00, 8'(mon_bad - nb)}, 16'h0010);
    $display("test nrz done");
    conclude();
  end
endmodule // testbench
`default_nettype wire

// ---- tple_encoder.sv ----
// Function
// - four prbs lengths chosen by two-bit select
// - zero limit: under 8 or under 15 zeros
// - t1 framed: framing bit kept, pattern pauses
// - e1 framed: ts0 and cas ts16 kept
// - written one requests one error, zero ignored; slip bit copies the written value
// - injected errors reach looped back data too, except the prbs request
// - violation request latched until served, self-clears
// - frame and crc requests invert next bit
// - alignment shift deletes, or inserts in e1
// - repeated shifts slip frames through read rate
// - prbs request inverts next generator bit
// - multiframe and cas requests invert next bit
// - t1 loop code repeats 4 to 7 bits
// - two-bit select picks line code for outputs
// - substitution done before crc data tap
// - ami: marks alternate, zeros send no pulse
// - hdb3: 000V or B00V, alternating violations
// - b8zs: eight zeros become 000VB0VB
// - bit 7 stuffing on enabled zero channels
// - umc: zero channel replaced by 10011000
// - density enforcer fills zeros, t1 data only
// - nrz select swaps monitor pins only
`timescale 1ns/1ns
`default_nettype none
module tple_encoder
  import tple_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_line_tick,
  input wire tple_word_type i_word,
  input wire logic i_word_valid,
  output logic o_word_ready,
  output logic o_sub_bit,
  output logic o_sub_valid,
  output logic o_line_out_a,
  output logic o_line_out_b,
  output logic o_monitor_positive_rail,
  output logic o_monitor_negative_rail
);
  logic [7:0] cfg0;
  logic [7:0] cfg1;
  logic [7:0] pat_cfg;
  logic [7:0] loop_cfg;
  logic [7:0] loop_pat;
  logic [7:0] err_req;
  logic [7:0] served;
  logic [7:0] chan_ctl [32];
  tple_word_type fifo_word;
  tple_word_type last_word;
  tple_word_type cur;
  tple_word_type a_word;
  tple_word_type out_w;
  tple_word_type win [WIN];
  logic fifo_valid, pop, step, del_pop, ins_now, del_now;
  logic e1, cas, hdb3, b8zs, hold, use_pat, lb_on;
  logic [22:0] lfsr;
  logic [3:0] zrun_pat, zlim_max;
  logic [2:0] lb_idx, lb_top;
  logic prbs_raw, pat_pre, pat_bit, a_bit;
  logic all_zero, chan_zero, zf, b;
  logic [3:0] pdv_zeros;
  logic [WIN-1:0] enc_p, enc_n, next_p, next_n, dly_d, dly_m;
  logic last_pol, next_last, pol, odd_marks, next_odd, lcv_take;
  logic [3:0] enc_zrun, next_zrun;
  logic [1:0] viol_left, next_viol;

  // mode decode
  assign e1 = cfg0[CFG0_E1];
  assign cas = cfg0[CFG0_CAS];
  assign hdb3 = e1 & (cfg1[1:0] != LC_AMI);
  assign b8zs = ~e1 & (cfg1[1:0] == LC_ZCS);

  // byte register writes
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg0 <= RST_BYTE;
      cfg1 <= RST_BYTE;
      pat_cfg <= RST_BYTE;
      loop_cfg <= RST_BYTE;
      loop_pat <= RST_BYTE;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_CFG_ZERO: cfg0 <= i_wdata;
        ADDR_CFG_ONE: cfg1 <= i_wdata;
        ADDR_PAT_CFG: pat_cfg <= i_wdata;
        ADDR_LOOP_CFG: loop_cfg <= i_wdata;
        ADDR_LOOP_PAT: loop_pat <= i_wdata;
        default: ;
      endcase
    end
  end

  // per-channel control bytes
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < 32; i++) begin
        chan_ctl[i] <= RST_BYTE;
      end
    end else if (i_wr && i_addr[8:5] == ADDR_CHAN_BASE[8:5]) begin
      chan_ctl[i_addr[4:0]] <= i_wdata;
    end
  end

  // error requests: a new write wins over a same-cycle serve
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      err_req <= RST_BYTE;
    end else if (i_wr && i_addr == ADDR_ERR_INS) begin
      err_req <= (err_req & ~served) | i_wdata;
      err_req[ERR_SLIP] <= i_wdata[ERR_SLIP];
    end else begin
      err_req <= err_req & ~served;
    end
  end

  // registered read data
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= RST_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_CFG_ZERO: o_rdata <= cfg0;
        ADDR_CFG_ONE: o_rdata <= cfg1;
        ADDR_ERR_INS: o_rdata <= err_req;
        ADDR_PAT_CFG: o_rdata <= pat_cfg;
        ADDR_LOOP_CFG: o_rdata <= loop_cfg;
        ADDR_LOOP_PAT: o_rdata <= loop_pat;
        default: begin
          if (i_addr[8:5] == ADDR_CHAN_BASE[8:5]) begin
            o_rdata <= chan_ctl[i_addr[4:0]];
          end else begin
            o_rdata <= RST_BYTE;
          end
        end
      endcase
    end
  end

  // input buffer between framer and line stage
  tple_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_in_valid(i_word_valid),
    .i_in_data(i_word),
    .o_in_ready(o_word_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_word),
    .i_out_ready(pop)
  );

  // alignment shift: t1 or slip 0 deletes, e1 slip 1 inserts
  assign ins_now = err_req[ERR_ALIGN] & e1 & err_req[ERR_SLIP];
  assign del_now = err_req[ERR_ALIGN] & ~ins_now;
  assign step = i_line_tick & (fifo_valid | ins_now);
  assign del_pop = del_now & fifo_valid & ~i_line_tick;
  assign pop = (step & ~ins_now) | del_pop;
  assign cur = ins_now ? last_word : fifo_word;

  // pattern and loop code selection
  assign hold = pat_cfg[PAT_FRAMED] &
                (e1 ? (cur.ts == TS_FAS | (cas & cur.ts == TS_CAS))
                    : cur.frame);
  assign use_pat = pat_cfg[PAT_GO] & ~hold;
  assign lb_on = loop_cfg[LOOP_GO] & ~e1 &
                 (~cur.frame | loop_cfg[LOOP_UNFR]);
  assign lb_top = LOOP_MIN_LEN - 3'h1 + {1'b0, loop_cfg[LOOP_LEN_LSB+:2]};
  assign prbs_raw = tple_prbs_fb(pat_cfg[PAT_SEL_LSB+:2], lfsr);
  assign zlim_max = pat_cfg[PAT_SEL_LSB+1] ? ZLIM_LONG : ZLIM_SHORT;
  assign pat_pre = prbs_raw |
                   (pat_cfg[PAT_ZLIM] & zrun_pat >= zlim_max - 4'h1);
  assign pat_bit = pat_pre ^ err_req[ERR_PRBS];

  // stage a data and error inversions
  always_comb begin
    a_bit = cur.data;
    if (use_pat) begin
      a_bit = pat_bit;
    end
    if (lb_on) begin
      a_bit = loop_pat[lb_idx];
    end
    a_bit = a_bit ^ (cur.frame & err_req[ERR_FRM])
                  ^ (cur.crc & err_req[ERR_CRC])
                  ^ (cur.mf & err_req[ERR_MF])
                  ^ (cur.mas & err_req[ERR_MAS]);
    a_word = cur;
    a_word.data = a_bit;
  end

  // which requests are consumed this cycle
  always_comb begin
    served = 8'h00;
    served[ERR_PRBS] = step & use_pat & ~lb_on;
    served[ERR_FRM] = step & cur.frame;
    served[ERR_CRC] = step & cur.crc;
    served[ERR_MF] = step & cur.mf;
    served[ERR_MAS] = step & cur.mas;
    served[ERR_ALIGN] = (step & ins_now) | del_pop;
    served[ERR_LCV] = step & lcv_take;
  end

  // prbs generator and zero-run tracking
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      lfsr <= PRBS_SEED;
      zrun_pat <= 4'h0;
    end else if (step & use_pat & ~lb_on) begin
      lfsr <= {lfsr[21:0], prbs_raw};
      zrun_pat <= pat_pre ? 4'h0 : zrun_pat + 4'h1;
    end
  end

  // loop code bit pointer, msb of the code first
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      lb_idx <= LOOP_MIN_LEN - 3'h1;
    end else if (!loop_cfg[LOOP_GO]) begin
      lb_idx <= lb_top;
    end else if (step & lb_on) begin
      lb_idx <= (lb_idx == 3'h0) ? lb_top : lb_idx - 3'h1;
    end
  end

  // substitution window of eight bits
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_word <= '0;
      for (int i = 0; i < WIN; i++) begin
        win[i] <= '0;
      end
    end else if (step) begin
      last_word <= cur;
      win[0] <= a_word;
      for (int i = 1; i < WIN; i++) begin
        win[i] <= win[i-1];
      end
    end
  end

  // channel zero check and data substitution
  always_comb begin
    out_w = win[WIN-1];
    all_zero = 1'b1;
    for (int i = 0; i < WIN; i++) begin
      if (win[i].data | win[i].frame) begin
        all_zero = 1'b0;
      end
    end
    zf = (out_w.pos == 3'h0) ? all_zero : chan_zero;
    b = out_w.data;
    if (~e1 & ~out_w.frame & zf) begin
      if (cfg1[1:0] == LC_UMC) begin
        b = UMC_CODE[~out_w.pos];
      end
      if (cfg1[1:0] == LC_B7ZS && chan_ctl[out_w.ts][CHAN_STUFF] &&
          out_w.pos == B7ZS_POS) begin
        b = 1'b1;
      end
    end
    if (~e1 & cfg1[CFG1_PDV] & ~out_w.frame &
        pdv_zeros >= PDV_MAX_ZEROS) begin
      b = 1'b1;
    end
  end

  // channel flag and density count, crc data tap
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      chan_zero <= 1'b0;
      pdv_zeros <= 4'h0;
      o_sub_bit <= 1'b0;
      o_sub_valid <= 1'b0;
    end else begin
      o_sub_valid <= step;
      if (step) begin
        chan_zero <= zf;
        pdv_zeros <= b ? 4'h0 : pdv_zeros + {3'h0, pdv_zeros != 4'hF};
        o_sub_bit <= b;
      end
    end
  end

  // dual-rail encoder with look-back rewrite
  always_comb begin
    next_p = {enc_p[WIN-2:0], 1'b0};
    next_n = {enc_n[WIN-2:0], 1'b0};
    next_last = last_pol;
    next_zrun = enc_zrun;
    next_odd = odd_marks;
    next_viol = viol_left;
    lcv_take = 1'b0;
    pol = ~last_pol;
    if (b) begin
      if (viol_left != 2'h0) begin
        pol = last_pol;
        next_viol = viol_left - 2'h1;
      end else if (err_req[ERR_LCV]) begin
        pol = last_pol;
        lcv_take = 1'b1;
        next_viol = hdb3 ? 2'h1 : 2'h0;
      end
      next_p[0] = pol;
      next_n[0] = ~pol;
      next_last = pol;
      next_zrun = 4'h0;
      next_odd = ~odd_marks;
    end else begin
      next_zrun = enc_zrun + {3'h0, enc_zrun != 4'hF};
      if (hdb3 && next_zrun >= HDB3_RUN) begin
        pol = last_pol;
        if (!odd_marks) begin
          next_p[3] = ~last_pol;
          next_n[3] = last_pol;
          pol = ~last_pol;
        end
        next_p[0] = pol;
        next_n[0] = ~pol;
        next_last = pol;
        next_zrun = 4'h0;
        next_odd = 1'b0;
      end else if (b8zs && next_zrun >= B8ZS_RUN) begin
        next_p[4] = last_pol;
        next_n[4] = ~last_pol;
        next_p[3] = ~last_pol;
        next_n[3] = last_pol;
        next_p[1] = ~last_pol;
        next_n[1] = last_pol;
        next_p[0] = last_pol;
        next_n[0] = ~last_pol;
        next_zrun = 4'h0;
      end
    end
  end

  // encoder state, line pins driven from the top window bits
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      enc_p <= '0;
      enc_n <= '0;
      dly_d <= '0;
      dly_m <= '0;
      last_pol <= 1'b0;
      enc_zrun <= 4'h0;
      odd_marks <= 1'b0;
      viol_left <= 2'h0;
    end else if (step) begin
      enc_p <= next_p;
      enc_n <= next_n;
      dly_d <= {dly_d[WIN-2:0], b};
      dly_m <= {dly_m[WIN-2:0], out_w.mfsync};
      last_pol <= next_last;
      enc_zrun <= next_zrun;
      odd_marks <= next_odd;
      viol_left <= next_viol;
    end
  end

  // monitor pair: dual rail or nrz plus multiframe sync
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_monitor_positive_rail <= 1'b0;
      o_monitor_negative_rail <= 1'b0;
    end else if (step) begin
      o_monitor_positive_rail <= cfg1[CFG1_NRZ] ? dly_d[WIN-2]
                                                : next_p[WIN-1];
      o_monitor_negative_rail <= cfg1[CFG1_NRZ] ? dly_m[WIN-2]
                                                : next_n[WIN-1];
    end
  end

  assign o_line_out_a = enc_p[WIN-1];
  assign o_line_out_b = enc_n[WIN-1];

  a_prbs_err_once:
  assert property (@(posedge i_mclk) disable iff (!i_resetn)
    step & use_pat & ~lb_on & err_req[ERR_PRBS] & ~i_wr
    |=> !err_req[ERR_PRBS]) else $error("prbs error not cleared");

  a_frame_err_once:
  assert property (@(posedge i_mclk) disable iff (!i_resetn)
    step & cur.frame & err_req[ERR_FRM] & ~i_wr
    |=> !err_req[ERR_FRM]) else $error("frame error not cleared");

  a_frame_pause:
  assert property (@(posedge i_mclk) disable iff (!i_resetn)
    step & ~e1 & pat_cfg[PAT_FRAMED] & cur.frame & ~i_wr
    |=> $stable(lfsr)) else $error("pattern ran over framing bit");

  a_stopped_idle:
  assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !pat_cfg[PAT_GO] |=> $stable(lfsr)) else $error("generator ran");

  a_zero_limit_run:
  assert property (@(posedge i_mclk) disable iff (!i_resetn)
    step & use_pat & ~lb_on & pat_cfg[PAT_ZLIM] &
    zrun_pat == zlim_max - 4'h1 |=> zrun_pat == 4'h0)
    else $error("zero run too long");

  a_hdb3_run:
  assert property (@(posedge i_mclk) disable iff (!i_resetn)
    step & hdb3 |=> enc_zrun < HDB3_RUN) else $error("hdb3 run");

  a_b8zs_run:
  assert property (@(posedge i_mclk) disable iff (!i_resetn)
    step & b8zs |=> enc_zrun < B8ZS_RUN) else $error("b8zs run");

  a_pdv_fill:
  assert property (@(posedge i_mclk) disable iff (!i_resetn)
    step & ~e1 & cfg1[CFG1_PDV] & ~out_w.frame &
    pdv_zeros >= PDV_MAX_ZEROS |=> pdv_zeros == 4'h0)
    else $error("density not enforced");

  a_rails_excl:
  assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !(o_line_out_a & o_line_out_b)) else $error("both rails high");
endmodule // tple_encoder
`default_nettype wire

// ---- tple_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module tple_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  // handshakes and head word
  assign o_in_ready = cnt != FULL;
  assign o_out_valid = cnt != '0;
  assign o_out_data = mem[rp];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // storage, no reset needed
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wp] <= i_in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + AW'(1);
      end
      if (pop) begin
        rp <= rp + AW'(1);
      end
      cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule // tple_fifo
`default_nettype wire

// ---- tple_line_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
module tple_line_partner (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_tick,
  input wire logic i_clear,
  input wire logic i_line_a,
  input wire logic i_line_b,
  input wire logic i_mon_p,
  input wire logic i_mon_n,
  output logic [15:0] o_marks,
  output logic [15:0] o_viols,
  output logic [7:0] o_same_v,
  output logic [7:0] o_mon_bad
);
  logic tick_d;
  logic last_pol;
  logic last_vpol;
  logic seen_v;
  // rails are looked at one cycle after each line tick
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) tick_d <= 1'b0;
    else tick_d <= i_tick;
  end
  // count pulses, violations and repeated violation polarity
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_marks <= 16'h0000;
      o_viols <= 16'h0000;
      o_same_v <= 8'h00;
      last_pol <= 1'b0;
      last_vpol <= 1'b0;
      seen_v <= 1'b0;
    end else if (i_clear) begin
      o_marks <= 16'h0000;
      o_viols <= 16'h0000;
      o_same_v <= 8'h00;
    end else if (tick_d && (i_line_a || i_line_b)) begin
      o_marks <= o_marks + 16'h0001;
      // equal polarity twice in a row is a violation
      if (i_line_a == last_pol) begin
        o_viols <= o_viols + 16'h0001;
        if (seen_v && i_line_a == last_vpol) o_same_v <= o_same_v + 8'h01;
        seen_v <= 1'b1;
        last_vpol <= i_line_a;
      end
      last_pol <= i_line_a;
    end
  end
  // monitor pair must mirror the line while nrz is off
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) o_mon_bad <= 8'h00;
    else if (tick_d && (i_mon_p !== i_line_a || i_mon_n !== i_line_b))
      o_mon_bad <= o_mon_bad + 8'h01;
  end
endmodule // tple_line_partner
`default_nettype wire

// ---- tple_pkg.sv ----
package tple_pkg;
  // register byte addresses
  localparam logic [8:0] ADDR_CFG_ZERO = 9'h070;
  localparam logic [8:0] ADDR_CFG_ONE = 9'h071;
  localparam logic [8:0] ADDR_ERR_INS = 9'h073;
  localparam logic [8:0] ADDR_PAT_CFG = 9'h076;
  localparam logic [8:0] ADDR_LOOP_CFG = 9'h077;
  localparam logic [8:0] ADDR_LOOP_PAT = 9'h078;
  localparam logic [8:0] ADDR_CHAN_BASE = 9'h100;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // transmit_config_zero fields
  localparam int CFG0_CAS = 3;
  localparam int CFG0_E1 = 4;
  // transmit_config_one fields
  localparam int CFG1_LC_LSB = 0;
  localparam int CFG1_PDV = 2;
  localparam int CFG1_NRZ = 3;
  // test_pattern_config fields
  localparam int PAT_SEL_LSB = 0;
  localparam int PAT_ZLIM = 2;
  localparam int PAT_FRAMED = 3;
  localparam int PAT_GO = 4;
  // transmit_error_insert fields
  localparam int ERR_LCV = 0;
  localparam int ERR_FRM = 1;
  localparam int ERR_CRC = 2;
  localparam int ERR_ALIGN = 3;
  localparam int ERR_SLIP = 4;
  localparam int ERR_PRBS = 5;
  localparam int ERR_MF = 6;
  localparam int ERR_MAS = 7;
  // loop_code_config fields, then the channel control stuff bit
  localparam int LOOP_GO = 0;
  localparam int LOOP_LEN_LSB = 1;
  localparam int LOOP_UNFR = 3;
  localparam int CHAN_STUFF = 0;
  // line code select values
  localparam logic [1:0] LC_AMI = 2'h0;
  localparam logic [1:0] LC_ZCS = 2'h1;
  localparam logic [1:0] LC_B7ZS = 2'h2;
  localparam logic [1:0] LC_UMC = 2'h3;
  localparam logic [7:0] UMC_CODE = 8'h98;
  // counts
  localparam logic [3:0] ZLIM_SHORT = 4'h8;
  localparam logic [3:0] ZLIM_LONG = 4'hF;
  localparam logic [3:0] HDB3_RUN = 4'h4;
  localparam logic [3:0] B8ZS_RUN = 4'h8;
  localparam logic [3:0] PDV_MAX_ZEROS = 4'hF;
  localparam logic [2:0] LOOP_MIN_LEN = 3'h4;
  localparam logic [2:0] B7ZS_POS = 3'h6;
  localparam logic [4:0] TS_FAS = 5'h00;
  localparam logic [4:0] TS_CAS = 5'h10;
  localparam logic [22:0] PRBS_SEED = 23'h7FFFFF;
  localparam int WIN = 8;
  localparam int FIFO_DEPTH = 8;

  // one line bit with its position markers from the framer
  typedef struct packed {
    logic data;
    logic frame;
    logic crc;
    logic mf;
    logic mas;
    logic mfsync;
    logic [4:0] ts;
    logic [2:0] pos;
  } tple_word_type;

  localparam int WORD_W = $bits(tple_word_type);

  // feedback bit of the selected prbs polynomial
  function automatic logic tple_prbs_fb(input logic [1:0] sel,
                                        input logic [22:0] s);
    logic fb;
    fb = 1'b0;
    unique case (sel)
      2'h0: fb = s[10] ^ s[8];
      2'h1: fb = s[14] ^ s[13];
      2'h2: fb = s[19] ^ s[2];
      2'h3: fb = s[22] ^ s[17];
    endcase
    return fb;
  endfunction
endpackage
